// file: pfs_pkg.sv
// constants shared by the fault status register bank
package pfs_pkg;

	// command codes of the status registers
	localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
	localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
	localparam logic [7:0] CMD_VOUT_FAULTS  = 8'h7a;
	localparam logic [7:0] CMD_IOUT_FAULTS  = 8'h7b;
	localparam logic [7:0] CMD_INPUT_FAULTS = 8'h7c;
	localparam logic [7:0] CMD_THERM_FAULTS = 8'h7d;
	localparam logic [7:0] CMD_COMM_FAULTS  = 8'h7e;
	localparam logic [7:0] CMD_MON_FAULTS   = 8'h80;

	// reset values
	localparam logic [15:0] SUMMARY_RESET = 16'h0000;
	localparam logic [7:0]  BYTE_RESET    = 8'h00;

	// category bytes: high fault in bit 7, low fault in bit 4
	localparam int CAT_HIGH_BIT = 7;
	localparam int CAT_LOW_BIT  = 4;
	localparam logic [7:0] CAT_MASK = 8'h90;

	// communication, memory and logic byte
	localparam int COMM_BAD_CMD_BIT  = 7;
	localparam int COMM_BAD_DATA_BIT = 6;
	localparam int COMM_PEC_BIT      = 5;
	localparam int COMM_MEM_BIT      = 4;
	localparam int COMM_OTHER_BIT    = 1;
	localparam logic [7:0] COMM_MASK = 8'hf2;

	// monitor and sync byte
	localparam int MON_SYNC_BIT   = 3;
	localparam int MON_AUX_UV_BIT = 1;
	localparam int MON_AUX_OV_BIT = 0;
	localparam logic [7:0] MON_MASK = 8'h0b;

	// summary word bit positions
	localparam int SW_VOUT    = 15;
	localparam int SW_IOUT    = 14;
	localparam int SW_INPUT   = 13;
	localparam int SW_MFR     = 12;
	localparam int SW_PG_N    = 11;
	localparam int SW_RSVD    = 10;
	localparam int SW_OTHER   = 9;
	localparam int SW_UNKNOWN = 8;
	localparam int SW_BUSY    = 7;
	localparam int SW_OFF     = 6;
	localparam int SW_VOUT_OV = 5;
	localparam int SW_IOUT_OC = 4;
	localparam int SW_VIN_UV  = 3;
	localparam int SW_TEMP    = 2;
	localparam int SW_COMM    = 1;
	localparam int SW_NONE    = 0;

	// response lengths in bytes
	localparam logic [1:0] LEN_NONE = 2'd0;
	localparam logic [1:0] LEN_BYTE = 2'd1;
	localparam logic [1:0] LEN_WORD = 2'd2;

	// width of the digitised auxiliary monitor sample
	localparam int AUX_W = 12;

endpackage

// file: pfs_sticky_byte.sv
// one byte of sticky fault flags with masked set and bulk clear
`timescale 1ns/1ns
`default_nettype none
module pfs_sticky_byte
	import pfs_pkg::*;
#(
	parameter logic [7:0] MASK = 8'hff
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// flag control
	input  wire logic [7:0] set,
	input  wire logic       clear,
	// flags
	output var  logic [7:0] flags
);

	typedef struct packed {
		logic [7:0] flags;
	} pfs_sticky_t;

	pfs_sticky_t s;
	pfs_sticky_t next_s;

	always_comb begin
		next_s = s;
		// set wins over clear, unused bits never set
		next_s.flags = ((s.flags & ~{8{clear}}) | set) & MASK;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s.flags <= BYTE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign flags = s.flags;

	property p_set_wins;
		@(posedge clk_sys) disable iff (!resetn)
		((set & MASK) != 8'h00) |=> ((flags & $past(set & MASK)) == $past(set & MASK));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag set lost");

	property p_unused_zero;
		@(posedge clk_sys) disable iff (!resetn)
		(flags & ~MASK) == 8'h00;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

endmodule
`default_nettype wire

// file: pfs_status_regs.sv
// fault status register bank: summary word and detail bytes
// What this block does
// - summary byte and low byte of summary word read one storage
// - summary word reads as two bytes, zero after reset
// - bits 15, 14, 13 flag output voltage, output current, input faults
// - bit 12 set while any monitor or sync fault is present
// - bit 11 set while power good is low
// - bit 10 reserved; bit 9 other flag; bit 8 unknown fault
// - bit 7 set when a busy fault is declared
// - bit 6 set whenever the output is not powered
// - bits 5, 4, 3, 2: output OV, output OC, input UV, temperature
// - bit 1 any comm fault; bit 0 fault outside bits 7 to 1
// - each detail byte reads as one read-only byte, zero after reset
// - output voltage byte: overvoltage bit 7, undervoltage bit 4
// - output current byte: overcurrent bit 7, undercurrent bit 4
// - input byte: overvoltage bit 7, undervoltage bit 4
// - temperature byte: over-temperature bit 7, under-temperature bit 4
// - comm byte bit 7 set on invalid or unsupported command code
// - comm byte bit 6 set on command with invalid data
// - comm byte bit 5 set on packet error; bits 3:2 and 0 reserved
// - comm byte bit 1 on write to read-only or other comm fault; bit 4 memory
// - monitor byte bit 3 on lost clock sync; bits 7:4 and 2 reserved
// - monitor byte bit 1 when aux input below low threshold
// - monitor byte bit 0 when aux input above high threshold
`timescale 1ns/1ns
`default_nettype none
module pfs_status_regs
	import pfs_pkg::*;
(
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	// fault events, one-cycle pulses from detection logic
	input  wire logic             vout_ov_evt,
	input  wire logic             vout_uv_evt,
	input  wire logic             iout_oc_evt,
	input  wire logic             iout_uc_evt,
	input  wire logic             vin_ov_evt,
	input  wire logic             vin_uv_evt,
	input  wire logic             ot_evt,
	input  wire logic             ut_evt,
	input  wire logic             bad_data_evt,
	input  wire logic             pec_err_evt,
	input  wire logic             mem_logic_evt,
	input  wire logic             comm_other_evt,
	input  wire logic             sync_lost_evt,
	input  wire logic             busy_evt,
	input  wire logic             other_evt,
	input  wire logic             unknown_evt,
	input  wire logic             clear_faults,
	// live conditions
	input  wire logic             power_good,
	input  wire logic             output_on,
	// auxiliary monitor
	input  wire logic [AUX_W-1:0] aux_monitor_input,
	input  wire logic             aux_sample,
	input  wire logic [AUX_W-1:0] aux_monitor_low_threshold,
	input  wire logic [AUX_W-1:0] aux_monitor_high_threshold,
	// command port
	input  wire logic             cmd_valid,
	input  wire logic             cmd_write,
	input  wire logic [7:0]       cmd_code,
	output var  logic             rsp_valid,
	output var  logic [15:0]      rsp_data,
	output var  logic [1:0]       rsp_len,
	output var  logic             rsp_unsupported,
	// summary mirror
	output var  logic [15:0]      summary_word,
	output var  logic             comm_memory_logic_flag
);

	function automatic logic is_status_code(input logic [7:0] code);
		case (code)
			CMD_SUMMARY_BYTE, CMD_SUMMARY_WORD, CMD_VOUT_FAULTS, CMD_IOUT_FAULTS,
			CMD_INPUT_FAULTS, CMD_THERM_FAULTS, CMD_COMM_FAULTS, CMD_MON_FAULTS: begin
				return 1'b1;
			end
			default: begin
				return 1'b0;
			end
		endcase
	endfunction

	function automatic logic [7:0] cat_set(input logic high, input logic low);
		logic [7:0] v;
		v = 8'h00;
		v[CAT_HIGH_BIT] = high;
		v[CAT_LOW_BIT] = low;
		return v;
	endfunction

	typedef struct packed {
		logic        busy;
		logic        other;
		logic        unknown;
		logic [15:0] summary;
		logic        rsp_valid;
		logic [15:0] rsp_data;
		logic [1:0]  rsp_len;
		logic        rsp_unsup;
		logic        comm_flag;
	} pfs_top_t;

	pfs_top_t s;
	pfs_top_t next_s;

	logic [7:0] vout_f;
	logic [7:0] iout_f;
	logic [7:0] input_f;
	logic [7:0] therm_f;
	logic [7:0] comm_f;
	logic [7:0] mon_f;
	logic [7:0] comm_set;
	logic [7:0] mon_set;
	logic       aux_uv;
	logic       aux_ov;
	logic       cmd_unsup;
	logic       cmd_ro_write;

	assign cmd_unsup = cmd_valid && !is_status_code(cmd_code);
	assign cmd_ro_write = cmd_valid && cmd_write && is_status_code(cmd_code);

	always_comb begin
		comm_set = 8'h00;
		comm_set[COMM_BAD_CMD_BIT] = cmd_unsup;
		comm_set[COMM_BAD_DATA_BIT] = bad_data_evt;
		comm_set[COMM_PEC_BIT] = pec_err_evt;
		comm_set[COMM_MEM_BIT] = mem_logic_evt;
		comm_set[COMM_OTHER_BIT] = cmd_ro_write || comm_other_evt;
		mon_set = 8'h00;
		mon_set[MON_SYNC_BIT] = sync_lost_evt;
		mon_set[MON_AUX_UV_BIT] = aux_uv;
		mon_set[MON_AUX_OV_BIT] = aux_ov;
	end

	pfs_aux_window u_aux (
		.clk_sys       (clk_sys),
		.resetn        (resetn),
		.sample        (aux_sample),
		.level         (aux_monitor_input),
		.low_threshold (aux_monitor_low_threshold),
		.high_threshold(aux_monitor_high_threshold),
		.below_evt     (aux_uv),
		.above_evt     (aux_ov)
	);

	// detail bytes
	pfs_sticky_byte #(.MASK(CAT_MASK)) u_vout (
		.clk_sys(clk_sys),
		.resetn (resetn),
		.set    (cat_set(vout_ov_evt, vout_uv_evt)),
		.clear  (clear_faults),
		.flags  (vout_f)
	);

	pfs_sticky_byte #(.MASK(CAT_MASK)) u_iout (
		.clk_sys(clk_sys),
		.resetn (resetn),
		.set    (cat_set(iout_oc_evt, iout_uc_evt)),
		.clear  (clear_faults),
		.flags  (iout_f)
	);

	pfs_sticky_byte #(.MASK(CAT_MASK)) u_input (
		.clk_sys(clk_sys),
		.resetn (resetn),
		.set    (cat_set(vin_ov_evt, vin_uv_evt)),
		.clear  (clear_faults),
		.flags  (input_f)
	);

	pfs_sticky_byte #(.MASK(CAT_MASK)) u_therm (
		.clk_sys(clk_sys),
		.resetn (resetn),
		.set    (cat_set(ot_evt, ut_evt)),
		.clear  (clear_faults),
		.flags  (therm_f)
	);

	pfs_sticky_byte #(.MASK(COMM_MASK)) u_comm (
		.clk_sys(clk_sys),
		.resetn (resetn),
		.set    (comm_set),
		.clear  (clear_faults),
		.flags  (comm_f)
	);

	pfs_sticky_byte #(.MASK(MON_MASK)) u_mon (
		.clk_sys(clk_sys),
		.resetn (resetn),
		.set    (mon_set),
		.clear  (clear_faults),
		.flags  (mon_f)
	);

	always_comb begin
		next_s = s;
		// single sticky flags, set wins over clear
		next_s.busy = (s.busy && !clear_faults) || busy_evt;
		next_s.other = (s.other && !clear_faults) || other_evt;
		next_s.unknown = (s.unknown && !clear_faults) || unknown_evt;
		// summary rebuilt every cycle from the detail flags, the single sticky flags and the live conditions
		next_s.summary[SW_VOUT] = |vout_f;
		next_s.summary[SW_IOUT] = |iout_f;
		next_s.summary[SW_INPUT] = |input_f;
		next_s.summary[SW_MFR] = |mon_f;
		next_s.summary[SW_PG_N] = !power_good;
		next_s.summary[SW_RSVD] = 1'b0;
		next_s.summary[SW_OTHER] = s.other;
		next_s.summary[SW_UNKNOWN] = s.unknown;
		next_s.summary[SW_BUSY] = s.busy;
		next_s.summary[SW_OFF] = !output_on;
		next_s.summary[SW_VOUT_OV] = vout_f[CAT_HIGH_BIT];
		next_s.summary[SW_IOUT_OC] = iout_f[CAT_HIGH_BIT];
		next_s.summary[SW_VIN_UV] = input_f[CAT_LOW_BIT];
		next_s.summary[SW_TEMP] = |therm_f;
		next_s.summary[SW_COMM] = |comm_f;
		// faults with no own bit in the low byte
		next_s.summary[SW_NONE] = vout_f[CAT_LOW_BIT] || iout_f[CAT_LOW_BIT]
			|| input_f[CAT_HIGH_BIT] || (|mon_f) || s.unknown || s.other;
		next_s.comm_flag = |comm_f;
		// command answer, one cycle after the request
		next_s.rsp_valid = cmd_valid;
		next_s.rsp_unsup = cmd_unsup;
		next_s.rsp_data = 16'h0000;
		next_s.rsp_len = LEN_NONE;
		if (cmd_valid && !cmd_write) begin
			case (cmd_code)
				CMD_SUMMARY_BYTE: begin
					next_s.rsp_data = {8'h00, s.summary[7:0]};
					next_s.rsp_len = LEN_BYTE;
				end
				CMD_SUMMARY_WORD: begin
					next_s.rsp_data = s.summary;
					next_s.rsp_len = LEN_WORD;
				end
				CMD_VOUT_FAULTS: begin
					next_s.rsp_data = {8'h00, vout_f};
					next_s.rsp_len = LEN_BYTE;
				end
				CMD_IOUT_FAULTS: begin
					next_s.rsp_data = {8'h00, iout_f};
					next_s.rsp_len = LEN_BYTE;
				end
				CMD_INPUT_FAULTS: begin
					next_s.rsp_data = {8'h00, input_f};
					next_s.rsp_len = LEN_BYTE;
				end
				CMD_THERM_FAULTS: begin
					next_s.rsp_data = {8'h00, therm_f};
					next_s.rsp_len = LEN_BYTE;
				end
				CMD_COMM_FAULTS: begin
					next_s.rsp_data = {8'h00, comm_f};
					next_s.rsp_len = LEN_BYTE;
				end
				CMD_MON_FAULTS: begin
					next_s.rsp_data = {8'h00, mon_f};
					next_s.rsp_len = LEN_BYTE;
				end
				default: begin
					next_s.rsp_data = 16'h0000;
					next_s.rsp_len = LEN_NONE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s.busy <= 1'b0;
			s.other <= 1'b0;
			s.unknown <= 1'b0;
			s.summary <= SUMMARY_RESET;
			s.rsp_valid <= 1'b0;
			s.rsp_data <= 16'h0000;
			s.rsp_len <= LEN_NONE;
			s.rsp_unsup <= 1'b0;
			s.comm_flag <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign rsp_valid = s.rsp_valid;
	assign rsp_data = s.rsp_data;
	assign rsp_len = s.rsp_len;
	assign rsp_unsupported = s.rsp_unsup;
	assign summary_word = s.summary;
	assign comm_memory_logic_flag = s.comm_flag;

	// checks
	property p_byte_alias;
		@(posedge clk_sys) disable iff (!resetn)
		(cmd_valid && !cmd_write && cmd_code == CMD_SUMMARY_BYTE)
		|=> rsp_valid && rsp_len == LEN_BYTE && rsp_data == {8'h00, $past(summary_word[7:0])};
	endproperty
	a_byte_alias: assert property (p_byte_alias) else $error("summary byte differs");

	property p_word_read;
		@(posedge clk_sys) disable iff (!resetn)
		(cmd_valid && !cmd_write && cmd_code == CMD_SUMMARY_WORD)
		|=> rsp_len == LEN_WORD && rsp_data == $past(summary_word);
	endproperty
	a_word_read: assert property (p_word_read) else $error("summary word read wrong");

	property p_vout_cat;
		@(posedge clk_sys) disable iff (!resetn)
		vout_ov_evt |-> ##2 summary_word[SW_VOUT] && summary_word[SW_VOUT_OV];
	endproperty
	a_vout_cat: assert property (p_vout_cat) else $error("output voltage bits missing");

	property p_mon_cat;
		@(posedge clk_sys) disable iff (!resetn)
		sync_lost_evt |-> ##2 summary_word[SW_MFR] && summary_word[SW_NONE];
	endproperty
	a_mon_cat: assert property (p_mon_cat) else $error("monitor summary bit missing");

	property p_pgood;
		@(posedge clk_sys) disable iff (!resetn)
		1'b1 |=> summary_word[SW_PG_N] == !$past(power_good) && !summary_word[SW_RSVD];
	endproperty
	a_pgood: assert property (p_pgood) else $error("power good bit wrong");

	property p_busy;
		@(posedge clk_sys) disable iff (!resetn)
		busy_evt |-> ##2 summary_word[SW_BUSY];
	endproperty
	a_busy: assert property (p_busy) else $error("busy bit missing");

	property p_off;
		@(posedge clk_sys) disable iff (!resetn)
		!output_on |=> summary_word[SW_OFF];
	endproperty
	a_off: assert property (p_off) else $error("off bit missing");

	property p_vin_uv;
		@(posedge clk_sys) disable iff (!resetn)
		vin_uv_evt |-> ##2 summary_word[SW_VIN_UV] && summary_word[SW_INPUT];
	endproperty
	a_vin_uv: assert property (p_vin_uv) else $error("input undervoltage bit missing");

	property p_unsup;
		@(posedge clk_sys) disable iff (!resetn)
		cmd_unsup |=> rsp_unsupported ##1 comm_memory_logic_flag && summary_word[SW_COMM];
	endproperty
	a_unsup: assert property (p_unsup) else $error("unsupported code not flagged");

	property p_ro_write;
		@(posedge clk_sys) disable iff (!resetn)
		cmd_ro_write |=> !rsp_unsupported && rsp_len == LEN_NONE ##1 summary_word[SW_COMM];
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write not flagged");

	property p_detail_agree;
		@(posedge clk_sys) disable iff (!resetn)
		1'b1 |=> summary_word[SW_IOUT] == (|$past(iout_f));
	endproperty
	a_detail_agree: assert property (p_detail_agree) else $error("summary disagrees");

	c_word_read: cover property (@(posedge clk_sys) disable iff (!resetn)
		cmd_valid && cmd_code == CMD_SUMMARY_WORD ##1 rsp_data != 16'h0000);
	c_unsup: cover property (@(posedge clk_sys) disable iff (!resetn) cmd_unsup);
	c_clear: cover property (@(posedge clk_sys) disable iff (!resetn)
		summary_word[SW_VOUT] ##1 clear_faults ##2 !summary_word[SW_VOUT]);

endmodule
`default_nettype wire

// file: pfs_aux_window.sv
// auxiliary monitor window comparator, registered event pulses
`timescale 1ns/1ns
`default_nettype none
module pfs_aux_window
	import pfs_pkg::*;
(
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	// sample and limits
	input  wire logic             sample,
	input  wire logic [AUX_W-1:0] level,
	input  wire logic [AUX_W-1:0] low_threshold,
	input  wire logic [AUX_W-1:0] high_threshold,
	// one-cycle events
	output var  logic             below_evt,
	output var  logic             above_evt
);

	typedef struct packed {
		logic below;
		logic above;
	} pfs_aux_t;

	pfs_aux_t s;
	pfs_aux_t next_s;

	always_comb begin
		next_s = s;
		next_s.below = sample && (level < low_threshold);
		next_s.above = sample && (level > high_threshold);
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign below_evt = s.below;
	assign above_evt = s.above;

	property p_below;
		@(posedge clk_sys) disable iff (!resetn)
		below_evt == $past(sample && (level < low_threshold));
	endproperty
	a_below: assert property (p_below) else $error("low threshold event wrong");

	property p_above;
		@(posedge clk_sys) disable iff (!resetn)
		above_evt == $past(sample && (level > high_threshold));
	endproperty
	a_above: assert property (p_above) else $error("high threshold event wrong");

endmodule
`default_nettype wire

// file: pfs_host_model.sv
// host side model: issues status commands and collects the answers
`timescale 1ns/1ns
`default_nettype none
module pfs_host_model
	import pfs_pkg::*;
(
	// clock
	input  wire logic        clk_sys,
	// request side
	output var  logic        cmd_valid,
	output var  logic        cmd_write,
	output var  logic [7:0]  cmd_code,
	// answer side
	input  wire logic        rsp_valid,
	input  wire logic [15:0] rsp_data,
	input  wire logic [1:0]  rsp_len,
	input  wire logic        rsp_unsupported
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code  = 8'h00;
	end

	// one request, held through the taking edge; the answer stands one cycle after it
	task automatic xfer(input logic [7:0] code, input logic wr, output logic v,
			output logic [15:0] d, output logic [1:0] l, output logic u);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_code  <= code;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		cmd_write <= 1'b0;
		// idle code is scrambled so no stale value looks valid
		cmd_code  <= ~code;
		// answer launched at this edge, gone after the next one
		@(negedge clk_sys);
		v = rsp_valid;
		d = rsp_data;
		l = rsp_len;
		u = rsp_unsupported;
	endtask
endmodule
`default_nettype wire

// file: pfs_status_regs_tb.sv
// self-checking bench for the fault status register bank
`timescale 1ns/1ns
`default_nettype none
module pfs_status_regs_tb
	import pfs_pkg::*;
;
	logic             clk_sys;
	logic             resetn;
	logic [15:0]      ev;
	logic             clear_faults;
	logic             power_good;
	logic             output_on;
	logic             aux_sample;
	logic [AUX_W-1:0] aux_lvl;
	logic [AUX_W-1:0] aux_lo;
	logic [AUX_W-1:0] aux_hi;
	logic             cmd_valid;
	logic             cmd_write;
	logic [7:0]       cmd_code;
	logic             rsp_valid;
	logic             rsp_unsupported;
	logic             comm_flag;
	logic [15:0]      rsp_data;
	logic [15:0]      summary_word;
	logic [1:0]       rsp_len;
	int               n_errors = 0;
	int               n_checks = 0;
	int               cycles = 0;

	// event order: vout ov/uv, iout oc/uc, vin ov/uv, ot/ut, comm x4, sync, busy, other, unk
	localparam logic [7:0] T_CODE [16] = '{8'h7a, 8'h7a, 8'h7b, 8'h7b, 8'h7c, 8'h7c, 8'h7d,
		8'h7d, 8'h7e, 8'h7e, 8'h7e, 8'h7e, 8'h80, 8'h79, 8'h79, 8'h79};
	localparam logic [15:0] T_DET [16] = '{16'h0080, 16'h0010, 16'h0080, 16'h0010, 16'h0080,
		16'h0010, 16'h0080, 16'h0010, 16'h0040, 16'h0020, 16'h0010, 16'h0002, 16'h0008,
		16'h0080, 16'h0201, 16'h0101};
	localparam logic [15:0] T_SUM [16] = '{16'h8020, 16'h8001, 16'h4010, 16'h4001, 16'h2001,
		16'h2008, 16'h0004, 16'h0004, 16'h0002, 16'h0002, 16'h0002, 16'h0002, 16'h1001,
		16'h0080, 16'h0201, 16'h0101};

	pfs_status_regs i_dut (
		.clk_sys(clk_sys), .resetn(resetn),
		.vout_ov_evt(ev[0]), .vout_uv_evt(ev[1]), .iout_oc_evt(ev[2]), .iout_uc_evt(ev[3]),
		.vin_ov_evt(ev[4]), .vin_uv_evt(ev[5]), .ot_evt(ev[6]), .ut_evt(ev[7]),
		.bad_data_evt(ev[8]), .pec_err_evt(ev[9]), .mem_logic_evt(ev[10]),
		.comm_other_evt(ev[11]), .sync_lost_evt(ev[12]), .busy_evt(ev[13]),
		.other_evt(ev[14]), .unknown_evt(ev[15]), .clear_faults(clear_faults),
		.power_good(power_good), .output_on(output_on),
		.aux_monitor_input(aux_lvl), .aux_sample(aux_sample),
		.aux_monitor_low_threshold(aux_lo), .aux_monitor_high_threshold(aux_hi),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_len(rsp_len),
		.rsp_unsupported(rsp_unsupported), .summary_word(summary_word),
		.comm_memory_logic_flag(comm_flag)
	);

	pfs_host_model i_host (
		.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_code(cmd_code), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_len(rsp_len), .rsp_unsupported(rsp_unsupported)
	);

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_errors++;
			end_sim();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic [1:0] len);
		logic        v;
		logic        u;
		logic [15:0] d;
		logic [1:0]  l;
		i_host.xfer(code, 1'b0, v, d, l, u);
		chk({12'h0, v, u, l}, {12'h0, 1'b1, 1'b0, len}, "read answer flags");
		chk(d, exp, "read data");
	endtask

	task automatic clr;
		@(posedge clk_sys);
		clear_faults <= 1'b1;
		@(posedge clk_sys);
		clear_faults <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic t_reset;
		logic [7:0] c [8] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80};
		for (int i = 0; i < 8; i++) begin
			rd(c[i], 16'h0000, (c[i] == 8'h79) ? LEN_WORD : LEN_BYTE);
		end
		chk({15'h0, comm_flag}, 16'h0, "comm flag after reset");
		$display("test reset values done");
	endtask

	task automatic t_events;
		for (int i = 0; i < 16; i++) begin
			clr();
			rd(8'h79, 16'h0000, LEN_WORD);
			@(posedge clk_sys);
			ev <= 16'h0001 << i;
			@(posedge clk_sys);
			ev <= 16'h0000;
			repeat (3) @(posedge clk_sys);
			rd(T_CODE[i], T_DET[i], (T_CODE[i] == 8'h79) ? LEN_WORD : LEN_BYTE);
			rd(8'h79, T_SUM[i], LEN_WORD);
			rd(8'h78, {8'h00, T_SUM[i][7:0]}, LEN_BYTE);
			chk({15'h0, comm_flag}, {15'h0, T_CODE[i] == 8'h7e}, "comm flag");
			chk(summary_word, T_SUM[i], "summary mirror");
		end
		$display("test fault events done");
	endtask

	task automatic t_levels;
		clr();
		@(posedge clk_sys);
		power_good <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rd(8'h79, 16'h0800, LEN_WORD);
		@(posedge clk_sys);
		power_good <= 1'b1;
		output_on  <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rd(8'h79, 16'h0040, LEN_WORD);
		rd(8'h78, 16'h0040, LEN_BYTE);
		@(posedge clk_sys);
		output_on <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd(8'h79, 16'h0000, LEN_WORD);
		$display("test live levels done");
	endtask

	task automatic t_aux;
		logic [AUX_W-1:0] lv [4] = '{12'h3ff, 12'h400, 12'hc00, 12'hc01};
		logic [7:0]       ex [4] = '{8'h02, 8'h00, 8'h00, 8'h01};
		for (int i = 0; i < 4; i++) begin
			clr();
			@(posedge clk_sys);
			aux_sample <= 1'b1;
			aux_lvl    <= lv[i];
			@(posedge clk_sys);
			aux_sample <= 1'b0;
			aux_lvl    <= ~lv[i];
			repeat (3) @(posedge clk_sys);
			rd(8'h80, {8'h00, ex[i]}, LEN_BYTE);
			rd(8'h79, (ex[i] != 8'h00) ? 16'h1001 : 16'h0000, LEN_WORD);
		end
		$display("test aux monitor done");
	endtask

	task automatic t_refuse;
		logic        v;
		logic        u;
		logic [15:0] d;
		logic [1:0]  l;
		clr();
		i_host.xfer(CMD_SUMMARY_WORD, 1'b1, v, d, l, u);
		chk({12'h0, v, u, l}, {12'h0, 4'b1000}, "write answer flags");
		chk(d, 16'h0000, "write answer data");
		repeat (2) @(posedge clk_sys);
		rd(CMD_COMM_FAULTS, 16'h0002, LEN_BYTE);
		rd(CMD_SUMMARY_WORD, 16'h0002, LEN_WORD);
		clr();
		i_host.xfer(8'h81, 1'b0, v, d, l, u);
		chk({12'h0, v, u, l}, {12'h0, 4'b1100}, "unsupported answer flags");
		repeat (2) @(posedge clk_sys);
		rd(CMD_COMM_FAULTS, 16'h0080, LEN_BYTE);
		rd(CMD_SUMMARY_WORD, 16'h0002, LEN_WORD);
		chk({15'h0, comm_flag}, 16'h0001, "comm flag set");
		$display("test refused requests done");
	endtask

	initial begin
		resetn       = 1'b0;
		ev           = 16'h0000;
		clear_faults = 1'b0;
		power_good   = 1'b1;
		output_on    = 1'b1;
		aux_sample   = 1'b0;
		aux_lvl      = 12'h000;
		aux_lo       = 12'h400;
		aux_hi       = 12'hc00;
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset();
		t_events();
		t_levels();
		t_aux();
		t_refuse();
		end_sim();
	end
endmodule
`default_nettype wire
